// *** design/asd_decoder.sv ***
/*
 * Address segment decoder: effective address, mode, segment and APB registers.
 * Assumes request, exception and return strobes come from logic on CLK.
 * Every output is registered; a result follows its request by one cycle.
 * All inputs share CLK, so none of them passes a synchroniser.
 */
// The implementer's own choices: the APB slave port and the address map.
`timescale 1ns/10ps
`default_nettype none

module asd_decoder (
	// Clock and reset
	input wire logic CLK,
	input wire logic ARST_N,
	// APB slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [asd_pkg::ASD_PADDR_W-1:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// Address request
	input wire logic REQ_VALID,
	input wire logic [63:0] REQ_BASE,
	input wire logic [asd_pkg::ASD_OFS_W-1:0] REQ_OFFSET,
	// Pipeline events
	input wire logic EXC_DETECT,
	input wire logic EXC_RETURN,
	// Decode result
	output logic RES_VALID,
	output asd_pkg::asd_kind_t RES_KIND,
	output logic [63:0] RES_VADDR,
	output logic [asd_pkg::ASD_TAG_W-1:0] RES_TAG,
	output logic [63:0] RES_PADDR,
	output logic RES_UNDEF,
	// Interrupt
	output logic IRQ
);
	import asd_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [ASD_ST_W-1:0] status;
	logic [ASD_ST_W-1:0] next_status;
	logic [ASD_TAG_W-1:0] tag;
	logic [ASD_TAG_W-1:0] next_tag;
	logic [ASD_IRQ_W-1:0] irq_stat;
	logic [ASD_IRQ_W-1:0] next_irq_stat;
	logic [ASD_IRQ_W-1:0] irq_mask;
	logic [ASD_IRQ_W-1:0] next_irq_mask;
	logic [63:0] fault;
	logic [63:0] next_fault;
	logic [31:0] next_prdata;
	logic next_pready;
	logic next_pslverr;
	logic next_irq;
	logic next_res_valid;
	asd_kind_t next_res_kind;
	logic [63:0] next_res_vaddr;
	logic [ASD_TAG_W-1:0] next_res_tag;
	logic [63:0] next_res_paddr;
	logic next_res_undef;

	// ----------------------------------------------------------------
	// Effective address and mode
	// ----------------------------------------------------------------
	asd_mode_t mode;
	logic wide;
	logic [63:0] sum;
	logic [63:0] eff;
	logic ovf;
	asd_kind_t dec_kind;
	logic [63:0] dec_paddr;

	always_comb begin
		mode = asd_mode_of(status[ASD_ST_PRIV_LSB+:2], status[ASD_ST_EXL],
			status[ASD_ST_ERL]);
		unique case (mode)
			ASD_MODE_KERN: wide = status[ASD_ST_KX];
			ASD_MODE_SUP: wide = status[ASD_ST_SX];
			ASD_MODE_USER: wide = status[ASD_ST_UX];
			default: wide = 1'b0;
		endcase
	end

	// Sign-extended offset added at full width
	always_comb begin
		sum = REQ_BASE + {{48{REQ_OFFSET[15]}}, REQ_OFFSET};
		eff = wide ? sum : {{32{sum[31]}}, sum[31:0]};
		ovf = !wide && ((!REQ_OFFSET[15] && !REQ_BASE[31] && sum[31]) ||
			(REQ_OFFSET[15] && REQ_BASE[31] && !sum[31]));
	end

	asd_seg_decode u_seg (
		.mode(mode),
		.wide(wide),
		.error_level_bit(status[ASD_ST_ERL]),
		.vaddr(eff),
		.kind(dec_kind),
		.paddr(dec_paddr)
	);

	// ----------------------------------------------------------------
	// APB access decode
	// ----------------------------------------------------------------
	logic acc_done;
	logic wr_done;
	logic rd_done;
	logic setup;
	logic hit;
	logic [31:0] rd_word;
	logic wr_status;
	logic wr_tag;
	logic wr_mask;
	logic rd_irq_clr;

	always_comb begin
		setup = PSEL && !PENABLE;
		acc_done = PSEL && PENABLE && PREADY;
		wr_done = acc_done && PWRITE;
		rd_done = acc_done && !PWRITE;
		hit = 1'b1;
		rd_word = 32'h0000_0000;
		unique case (PADDR)
			ASD_OFS_STATUS: rd_word = {24'h000000, status};
			ASD_OFS_TAG: rd_word = {24'h000000, tag};
			ASD_OFS_IRQ_STAT: rd_word = {29'h0, irq_stat};
			ASD_OFS_IRQ_MASK: rd_word = {29'h0, irq_mask};
			ASD_OFS_FAULT_LO: rd_word = fault[31:0];
			ASD_OFS_FAULT_HI: rd_word = fault[63:32];
			default: hit = 1'b0;
		endcase
		wr_status = wr_done && PADDR == ASD_OFS_STATUS;
		wr_tag = wr_done && PADDR == ASD_OFS_TAG;
		wr_mask = wr_done && PADDR == ASD_OFS_IRQ_MASK;
		rd_irq_clr = rd_done && PADDR == ASD_OFS_IRQ_STAT;
	end

	// ----------------------------------------------------------------
	// Request events
	// ----------------------------------------------------------------
	logic addr_err_evt;
	logic ovf_evt;

	always_comb begin
		addr_err_evt = REQ_VALID && dec_kind == ASD_ADDR_ERR;
		ovf_evt = REQ_VALID && ovf;
	end

	// ----------------------------------------------------------------
	// APB answer
	// ----------------------------------------------------------------
	always_comb begin
		// Bus answer one cycle after setup
		next_pready = setup;
		next_prdata = (setup && !PWRITE && hit) ? rd_word : 32'h0000_0000;
		next_pslverr = setup && !hit;
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			PRDATA <= 32'h0000_0000;
			PREADY <= 1'b0;
			PSLVERR <= 1'b0;
		end else begin
			PRDATA <= next_prdata;
			PREADY <= next_pready;
			PSLVERR <= next_pslverr;
		end
	end

	// ----------------------------------------------------------------
	// Status, tag and mask
	// ----------------------------------------------------------------
	always_comb begin
		next_status = status;
		if (wr_status)
			next_status = PWDATA[ASD_ST_W-1:0];
		// Return drops the error level first
		if (EXC_RETURN) begin
			if (status[ASD_ST_ERL])
				next_status[ASD_ST_ERL] = 1'b0;
			else
				next_status[ASD_ST_EXL] = 1'b0;
		end
		// Entry wins over write and return
		if (EXC_DETECT || addr_err_evt)
			next_status[ASD_ST_EXL] = 1'b1;

		next_tag = tag;
		if (wr_tag)
			next_tag = PWDATA[ASD_TAG_W-1:0];

		next_irq_mask = irq_mask;
		if (wr_mask)
			next_irq_mask = PWDATA[ASD_IRQ_W-1:0];
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			status <= ASD_ST_RST;
			tag <= ASD_TAG_RST;
			irq_mask <= ASD_IRQ_RST;
		end else begin
			status <= next_status;
			tag <= next_tag;
			irq_mask <= next_irq_mask;
		end
	end

	// ----------------------------------------------------------------
	// Interrupt status
	// ----------------------------------------------------------------
	always_comb begin
		// Read clears only the bits it reported; new events win
		next_irq_stat = irq_stat;
		if (rd_irq_clr)
			next_irq_stat = irq_stat & ~PRDATA[ASD_IRQ_W-1:0];
		if (addr_err_evt)
			next_irq_stat[ASD_IRQ_ADDR_ERR] = 1'b1;
		if (ovf_evt)
			next_irq_stat[ASD_IRQ_OVERFLOW] = 1'b1;
		if (EXC_DETECT)
			next_irq_stat[ASD_IRQ_EXC] = 1'b1;
		next_irq = |(next_irq_stat & next_irq_mask);
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			irq_stat <= ASD_IRQ_RST;
			IRQ <= 1'b0;
		end else begin
			irq_stat <= next_irq_stat;
			IRQ <= next_irq;
		end
	end

	// ----------------------------------------------------------------
	// Fault address
	// ----------------------------------------------------------------
	always_comb begin
		// Last address that raised an address error
		next_fault = addr_err_evt ? eff : fault;
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N)
			fault <= 64'h0000_0000_0000_0000;
		else
			fault <= next_fault;
	end

	// ----------------------------------------------------------------
	// Decode result
	// ----------------------------------------------------------------
	always_comb begin
		next_res_valid = REQ_VALID;
		next_res_kind = dec_kind;
		next_res_vaddr = eff;
		next_res_tag = (dec_kind == ASD_MAPPED) ? tag : ASD_TAG_RST;
		next_res_paddr = dec_paddr;
		next_res_undef = ovf_evt;
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			RES_VALID <= 1'b0;
			RES_KIND <= ASD_MAPPED;
			RES_VADDR <= 64'h0000_0000_0000_0000;
			RES_TAG <= ASD_TAG_RST;
			RES_PADDR <= 64'h0000_0000_0000_0000;
			RES_UNDEF <= 1'b0;
		end else begin
			RES_VALID <= next_res_valid;
			RES_KIND <= next_res_kind;
			RES_VADDR <= next_res_vaddr;
			RES_TAG <= next_res_tag;
			RES_PADDR <= next_res_paddr;
			RES_UNDEF <= next_res_undef;
		end
	end

endmodule // asd_decoder

`default_nettype wire

// *** design/asd_pkg.sv ***
/*
 * Constants, types and shared decode helpers of the address segment decoder.
 * Assumes a single 100 MHz core clock and a 32-bit APB register port.
 */
`default_nettype none

package asd_pkg;

	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int ASD_VA_W = 64;
	localparam int ASD_TAG_W = 8;
	localparam int ASD_OFS_W = 16;
	localparam int ASD_PADDR_W = 12;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {ASD_MAPPED, ASD_CACHED, ASD_UNCACHED, ASD_ADDR_ERR} asd_kind_t;
	typedef enum logic [1:0] {ASD_MODE_KERN, ASD_MODE_SUP, ASD_MODE_USER} asd_mode_t;

	// ----------------------------------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [11:0] ASD_OFS_STATUS = 12'h000;
	localparam logic [11:0] ASD_OFS_TAG = 12'h004;
	localparam logic [11:0] ASD_OFS_IRQ_STAT = 12'h008;
	localparam logic [11:0] ASD_OFS_IRQ_MASK = 12'h00C;
	localparam logic [11:0] ASD_OFS_FAULT_LO = 12'h010;
	localparam logic [11:0] ASD_OFS_FAULT_HI = 12'h014;

	// ----------------------------------------------------------------
	// Status register fields
	// ----------------------------------------------------------------
	localparam int ASD_ST_W = 8;
	localparam int ASD_ST_EXL = 1;
	localparam int ASD_ST_ERL = 2;
	localparam int ASD_ST_PRIV_LSB = 3;
	localparam int ASD_ST_UX = 5;
	localparam int ASD_ST_SX = 6;
	localparam int ASD_ST_KX = 7;
	localparam logic [ASD_ST_W-1:0] ASD_ST_RST = 8'h04;
	localparam logic [ASD_TAG_W-1:0] ASD_TAG_RST = 8'h00;

	localparam logic [1:0] ASD_PRIV_KERN = 2'h0;
	localparam logic [1:0] ASD_PRIV_SUP = 2'h1;
	localparam logic [1:0] ASD_PRIV_USER = 2'h2;

	// ----------------------------------------------------------------
	// Interrupt status fields
	// ----------------------------------------------------------------
	localparam int ASD_IRQ_W = 3;
	localparam int ASD_IRQ_ADDR_ERR = 0;
	localparam int ASD_IRQ_OVERFLOW = 1;
	localparam int ASD_IRQ_EXC = 2;
	localparam logic [ASD_IRQ_W-1:0] ASD_IRQ_RST = 3'h0;

	// ----------------------------------------------------------------
	// Segment constants
	// ----------------------------------------------------------------
	localparam logic [2:0] ASD_TOP_CACHED = 3'h4;
	localparam logic [2:0] ASD_TOP_UNCACHED = 3'h5;
	localparam logic [2:0] ASD_TOP_SUPSEG = 3'h6;
	localparam logic [1:0] ASD_HI_USER = 2'h0;
	localparam logic [1:0] ASD_HI_SUP = 2'h1;
	localparam logic [1:0] ASD_HI_PHYS = 2'h2;
	localparam logic [1:0] ASD_HI_KERN = 2'h3;
	localparam logic [31:0] ASD_CACHED_BASE = 32'h8000_0000;
	localparam logic [31:0] ASD_UNCACHED_BASE = 32'hA000_0000;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Mode from privilege field and level bits
	function automatic asd_mode_t asd_mode_of(input logic [1:0] priv, input logic exception_level_bit,
		input logic error_level_bit);
		if (exception_level_bit || error_level_bit || priv == ASD_PRIV_KERN)
			return ASD_MODE_KERN;
		else if (priv == ASD_PRIV_SUP)
			return ASD_MODE_SUP;
		else
			return ASD_MODE_USER;
	endfunction

	// Kernel 32-bit segment kind from the low word's top bits
	function automatic asd_kind_t asd_kern32_kind(input logic [2:0] top3);
		if (top3 == ASD_TOP_CACHED)
			return ASD_CACHED;
		else if (top3 == ASD_TOP_UNCACHED)
			return ASD_UNCACHED;
		else
			return ASD_MAPPED;
	endfunction

endpackage

`default_nettype wire

// *** design/asd_seg_decode.sv ***
/*
 * Combinational segment decode of one 64-bit virtual address.
 * Assumes the address is already sign extended when 32-bit decoding applies.
 */
`timescale 1ns/10ps
`default_nettype none

module asd_seg_decode (
	// Mode
	input wire asd_pkg::asd_mode_t mode,
	input wire logic wide,
	input wire logic error_level_bit,
	// Address
	input wire logic [63:0] vaddr,
	// Result
	output asd_pkg::asd_kind_t kind,
	output logic [63:0] paddr
);
	import asd_pkg::*;

	logic mid_zero;
	logic compat;
	logic [31:0] low_pa;

	always_comb begin
		mid_zero = (vaddr[61:40] == 22'h000000);
		compat = &vaddr[63:31];
		kind = ASD_ADDR_ERR;
		low_pa = 32'h0000_0000;
		unique case (mode)
			ASD_MODE_USER: begin
				if (!wide)
					kind = vaddr[31] ? ASD_ADDR_ERR : ASD_MAPPED;
				else
					kind = (vaddr[63:40] == 24'h000000) ? ASD_MAPPED : ASD_ADDR_ERR;
			end
			ASD_MODE_SUP: begin
				if (!wide) begin
					if (!vaddr[31])
						kind = ASD_MAPPED;
					else if (vaddr[31:29] == ASD_TOP_SUPSEG)
						kind = ASD_MAPPED;
					else
						kind = ASD_ADDR_ERR;
				end else begin
					if (vaddr[63:62] == ASD_HI_USER && mid_zero)
						kind = ASD_MAPPED;
					else if (vaddr[63:62] == ASD_HI_SUP && mid_zero)
						kind = ASD_MAPPED;
					else if (compat && vaddr[31:29] == ASD_TOP_SUPSEG)
						kind = ASD_MAPPED;
					else
						kind = ASD_ADDR_ERR;
				end
			end
			ASD_MODE_KERN: begin
				if (!wide) begin
					kind = asd_kern32_kind(vaddr[31:29]);
					if (!vaddr[31] && error_level_bit)
						kind = ASD_UNCACHED;
				end else begin
					unique case (vaddr[63:62])
						ASD_HI_USER: begin
							kind = mid_zero ? ASD_MAPPED : ASD_ADDR_ERR;
							if (error_level_bit && vaddr[63:31] == 33'h0)
								kind = ASD_UNCACHED;
						end
						ASD_HI_SUP:
							kind = mid_zero ? ASD_MAPPED : ASD_ADDR_ERR;
						ASD_HI_PHYS:
							kind = (vaddr[58:32] == 27'h0) ? ASD_CACHED : ASD_ADDR_ERR;
						ASD_HI_KERN: begin
							if (compat)
								kind = asd_kern32_kind(vaddr[31:29]);
							else if (mid_zero && !(&vaddr[39:31]))
								kind = ASD_MAPPED;
							else
								kind = ASD_ADDR_ERR;
						end
					endcase
				end
			end
			default: kind = ASD_ADDR_ERR;
		endcase
		// Unmapped physical address
		if (kind == ASD_CACHED && !(mode == ASD_MODE_KERN && wide && vaddr[63:62] == ASD_HI_PHYS))
			low_pa = vaddr[31:0] - ASD_CACHED_BASE;
		else if (kind == ASD_UNCACHED && vaddr[31])
			low_pa = vaddr[31:0] - ASD_UNCACHED_BASE;
		else if (kind != ASD_MAPPED && kind != ASD_ADDR_ERR)
			low_pa = vaddr[31:0];
		paddr = {32'h0000_0000, low_pa};
	end

endmodule // asd_seg_decode

`default_nettype wire

// *** verification/asd_agen_model.sv ***
/* Address generator model: decode requests and pipeline events.
   Steered by task calls from the bench, on clk. */
`timescale 1ns/10ps
`default_nettype none
module asd_agen_model (
	// Clock
	input wire logic clk,
	// Requests and events
	output logic req_valid,
	output logic [63:0] req_base,
	output logic [15:0] req_offset,
	output logic exc_detect,
	output logic exc_return
);
	initial begin
		req_valid = 1'b0;
		req_base = 64'h0;
		req_offset = 16'h0;
		exc_detect = 1'b0;
		exc_return = 1'b0;
	end
	task automatic issue(input logic [63:0] b, input logic [15:0] o);
		@(posedge clk);
		req_valid <= 1'b1;
		req_base <= b;
		req_offset <= o;
		@(posedge clk);
		req_valid <= 1'b0;
		// Stale operands inverted, not held
		req_base <= ~b;
		req_offset <= ~o;
	endtask
	task automatic pulse(input logic ret);
		@(posedge clk);
		exc_return <= ret;
		exc_detect <= !ret;
		@(posedge clk);
		exc_return <= 1'b0;
		exc_detect <= 1'b0;
	endtask
endmodule // asd_agen_model
`default_nettype wire

// *** verification/asd_decoder_asserts.sv ***
/* Port checker of the address segment decoder.
   Bound to the top module by the bench; sees its ports only. */
`timescale 1ns/10ps
`default_nettype none
module asd_decoder_asserts (
	// Clock and reset
	input wire logic CLK,
	input wire logic ARST_N,
	// APB
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic [11:0] PADDR,
	input wire logic PREADY,
	input wire logic PSLVERR,
	// Request and result
	input wire logic REQ_VALID,
	input wire logic [63:0] REQ_BASE,
	input wire logic [15:0] REQ_OFFSET,
	input wire logic RES_VALID,
	input wire asd_pkg::asd_kind_t RES_KIND,
	input wire logic [63:0] RES_VADDR,
	input wire logic [7:0] RES_TAG,
	input wire logic [63:0] RES_PADDR,
	input wire logic RES_UNDEF
);
	import asd_pkg::*;
	logic [31:0] sum;
	logic ovf;
	assign sum = REQ_BASE[31:0] + {{16{REQ_OFFSET[15]}}, REQ_OFFSET};
	assign ovf = (REQ_OFFSET[15] == REQ_BASE[31]) && (sum[31] != REQ_BASE[31]);
	default clocking @(posedge CLK); endclocking
	default disable iff (!ARST_N);
	a_res_latency:
		assert property (REQ_VALID |=> RES_VALID) else $error("Result missing");
	a_res_quiet:
		assert property (!REQ_VALID |=> !RES_VALID) else $error("Spurious result");
	a_undef_cause:
		assert property (RES_VALID && RES_UNDEF |-> $past(ovf)) else $error("Bad undef");
	a_cached_pa:
		assert property (RES_VALID && RES_KIND == ASD_CACHED && RES_VADDR[63:62] != 2'h2
			|-> RES_PADDR == {32'h0, RES_VADDR[31:0] - 32'h8000_0000}) else $error("Cached PA");
	a_uncached_pa:
		assert property (RES_VALID && RES_KIND == ASD_UNCACHED && RES_VADDR[31:29] == 3'h5
			|-> RES_PADDR == {32'h0, RES_VADDR[31:0] - 32'hA000_0000}) else $error("Uncached PA");
	a_tag_clear:
		assert property (RES_VALID && RES_KIND != ASD_MAPPED |-> RES_TAG == 8'h00)
			else $error("Stray tag");
	a_pa_clear:
		assert property (RES_VALID && (RES_KIND == ASD_MAPPED || RES_KIND == ASD_ADDR_ERR)
			|-> RES_PADDR == 64'h0) else $error("Stray PA");
	a_wide_gap:
		assert property (RES_VALID && !RES_VADDR[63] && RES_VADDR[61:40] != 22'h0
			|-> RES_KIND == ASD_ADDR_ERR) else $error("Gap not error");
	a_apb_ready:
		assert property (PSEL && !PENABLE |=> PREADY ##1 !PREADY) else $error("PREADY timing");
	a_slverr_map:
		assert property (PSEL && !PENABLE && PADDR > 12'h014 |=> PSLVERR && PREADY)
			else $error("No PSLVERR");
	c_addr_err: cover property (RES_VALID && RES_KIND == ASD_ADDR_ERR);
	c_undef: cover property (RES_VALID && RES_UNDEF);
	c_slverr: cover property (PSLVERR);
endmodule // asd_decoder_asserts
`default_nettype wire

// *** verification/asd_decoder_tb.sv ***
/* Bench of the address segment decoder: APB tasks and decode checks.
   Requests come through the generator model; the checker is bound. */
`timescale 1ns/10ps
`default_nettype none
module asd_decoder_tb;
	import asd_pkg::*;
	logic CLK, ARST_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, RES_VALID, RES_UNDEF, IRQ;
	logic REQ_VALID, EXC_DETECT, EXC_RETURN;
	logic [11:0] PADDR;
	logic [31:0] PWDATA, PRDATA, rd;
	logic [63:0] REQ_BASE, RES_VADDR, RES_PADDR;
	logic [15:0] REQ_OFFSET;
	logic [7:0] RES_TAG, etag;
	asd_kind_t RES_KIND;
	int n_fail = 0;
	int n_checks = 0;
	asd_decoder dut (.*);
	asd_agen_model agen (.clk(CLK), .req_valid(REQ_VALID), .req_base(REQ_BASE),
		.req_offset(REQ_OFFSET), .exc_detect(EXC_DETECT), .exc_return(EXC_RETURN));
	initial begin
		CLK = 1'b0;
		forever #5 CLK = ~CLK;
	end
	// ----
	// Tasks
	// ----
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict();
		$display("checks=%0d mismatches=%0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic e);
		@(posedge CLK);
		PSEL <= 1'b1;
		PENABLE <= 1'b0;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLK);
		PENABLE <= 1'b1;
		@(posedge CLK);
		while (PREADY !== 1'b1)
			@(posedge CLK);
		rd = PRDATA;
		chk(PSLVERR, e);
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 1'b0);
	endtask
	task automatic rdc(input logic [11:0] a, input logic [31:0] x, input logic e);
		apb(1'b0, a, 32'h0, e);
		chk(rd, x);
	endtask
	// Decode at base b plus offset o; an error is returned from at once
	task automatic dec(input logic [63:0] b, input logic [15:0] o, input logic [1:0] k,
		input logic [63:0] pa);
		agen.issue(b, o);
		#1;
		chk(RES_VALID, 1'b1);
		chk(RES_KIND, k);
		chk(RES_PADDR, pa);
		chk(RES_TAG, (k == ASD_MAPPED) ? etag : 8'h00);
		if (k == ASD_ADDR_ERR)
			agen.pulse(1'b1);
	endtask
	// ----
	// Tests
	// ----
	initial begin
		ARST_N = 1'b0;
		PSEL = 1'b0;
		PENABLE = 1'b0;
		PWRITE = 1'b0;
		PADDR = 12'h000;
		PWDATA = 32'h0;
		etag = 8'h00;
		repeat (2) @(posedge CLK);
		ARST_N <= 1'b1;
		rdc(ASD_OFS_STATUS, 32'h04, 1'b0);
		rdc(ASD_OFS_TAG, 32'h0, 1'b0);
		rdc(12'h018, 32'h0, 1'b1);
		$display("reset test done");
		dec(64'h8000_1234, 16'h0, ASD_CACHED, 64'h1234);
		chk(RES_VADDR, 64'hFFFF_FFFF_8000_1234);
		chk(RES_UNDEF, 1'b0);
		dec(64'hA000_0010, 16'h0, ASD_UNCACHED, 64'h10);
		dec(64'hE000_0000, 16'h0, ASD_MAPPED, 64'h0);
		dec(64'h7FFF_FFF0, 16'h0020, ASD_CACHED, 64'h10);
		chk(RES_UNDEF, 1'b1);
		dec(64'hFFFF_FFFF_8000_0000, 16'hFFFF, ASD_UNCACHED, 64'h7FFF_FFFF);
		chk(RES_UNDEF, 1'b1);
		rdc(ASD_OFS_IRQ_STAT, 32'h2, 1'b0);
		$display("kernel narrow test done");
		wr(ASD_OFS_STATUS, 32'h08);
		wr(ASD_OFS_TAG, 32'h5A);
		etag = 8'h5A;
		wr(ASD_OFS_IRQ_MASK, 32'h7);
		dec(64'h7FFF_FFFF, 16'h0, ASD_MAPPED, 64'h0);
		dec(64'hDFFF_FFFF, 16'h0, ASD_MAPPED, 64'h0);
		dec(64'hE000_0000, 16'h0, ASD_ADDR_ERR, 64'h0);
		chk(IRQ, 1'b1);
		rdc(ASD_OFS_IRQ_STAT, 32'h1, 1'b0);
		rdc(ASD_OFS_FAULT_HI, 32'hFFFF_FFFF, 1'b0);
		chk(IRQ, 1'b0);
		agen.pulse(1'b0);
		dec(64'h8000_0000, 16'h0, ASD_CACHED, 64'h0);
		agen.pulse(1'b1);
		dec(64'h8000_0000, 16'h0, ASD_ADDR_ERR, 64'h0);
		rdc(ASD_OFS_IRQ_STAT, 32'h5, 1'b0);
		$display("supervisor narrow test done");
		wr(ASD_OFS_STATUS, 32'h48);
		dec(64'h0000_00FF_FFFF_FFFF, 16'h0, ASD_MAPPED, 64'h0);
		dec(64'h4000_0000_0000_0000, 16'h0, ASD_MAPPED, 64'h0);
		dec(64'hFFFF_FFFF_C000_0000, 16'h0, ASD_MAPPED, 64'h0);
		dec(64'h8000_0000_0000_0000, 16'h0, ASD_ADDR_ERR, 64'h0);
		$display("supervisor wide test done");
		wr(ASD_OFS_STATUS, 32'h80);
		dec(64'h4000_0100_0000_0000, 16'h0, ASD_ADDR_ERR, 64'h0);
		dec(64'hC000_00FF_8000_0000, 16'h0, ASD_ADDR_ERR, 64'h0);
		dec(64'hC000_00FF_7FFF_FFFF, 16'h0, ASD_MAPPED, 64'h0);
		dec(64'h8000_0000_1234_5678, 16'h0, ASD_CACHED, 64'h1234_5678);
		wr(ASD_OFS_STATUS, 32'h84);
		dec(64'h0000_0000_0000_1000, 16'h0, ASD_UNCACHED, 64'h1000);
		dec(64'hFFFF_FFFF_9000_0000, 16'h0, ASD_CACHED, 64'h1000_0000);
		dec(64'hFFFF_FFFF_A000_0010, 16'h0, ASD_UNCACHED, 64'h10);
		$display("kernel wide test done");
		wr(ASD_OFS_STATUS, 32'h10);
		wr(ASD_OFS_IRQ_MASK, 32'h0);
		dec(64'h8000_0000, 16'h0, ASD_ADDR_ERR, 64'h0);
		chk(IRQ, 1'b0);
		wr(ASD_OFS_STATUS, 32'h30);
		dec(64'h0000_00FF_FFFF_FFFF, 16'h0, ASD_MAPPED, 64'h0);
		dec(64'h0000_0100_0000_0000, 16'h0, ASD_ADDR_ERR, 64'h0);
		wr(ASD_OFS_STATUS, 32'h12);
		dec(64'h8000_0000, 16'h0, ASD_CACHED, 64'h0);
		$display("user test done");
		print_verdict();
	end
	// Cut a hang far beyond the expected run
	initial begin
		#200000;
		n_fail++;
		print_verdict();
	end
endmodule // asd_decoder_tb
bind asd_decoder asd_decoder_asserts chk_i (.*);
`default_nettype wire
